// *** hdl/agr_pkg.sv ***
// package of offsets, widths and reset values for the gateway register bank
// assumes a 32-bit AXI4-Lite bus with byte addressing
`default_nettype none
package agr_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 4;
   // byte offsets of the two register words in each interface map; each map starts at zero
   localparam logic [3:0] OFS_WORD_A = 4'h0;
   localparam logic [3:0] OFS_WORD_B = 4'h4;
   localparam int unsigned WORD_LSB = 2;
   localparam logic [31:0] RST_WORD = 32'h00000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage
`default_nettype wire

// *** hdl/agr_wr_slave.sv ***
// write channel of the input-port map: holds the host-writable words
// assumes awvalid/wvalid/bready from an AXI4-Lite master on core_clk
`timescale 1ns/10ps
`default_nettype none
module agr_wr_slave #(
   parameter int unsigned IN_W_A = 32,
   parameter int unsigned IN_W_B = 32
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [agr_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // stored words
   output logic [31:0] word_a_ff,
   output logic [31:0] word_b_ff
);
   // -------------------------------------------------------
   // accept address and data together, one transfer at a time
   // -------------------------------------------------------
   logic take;
   logic [31:0] mask_a;
   logic [31:0] mask_b;
   logic [31:0] strb_mask;
   assign take = awvalid && wvalid && !bvalid;
   assign mask_a = (IN_W_A >= 32) ? 32'hFFFFFFFF : ((32'h00000001 << IN_W_A) - 32'h00000001); // R05
   assign mask_b = (IN_W_B >= 32) ? 32'hFFFFFFFF : ((32'h00000001 << IN_W_B) - 32'h00000001); // R05
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_strb
         assign strb_mask[gi*8 +: 8] = {8{wstrb[gi]}};
      end
   endgenerate
   // ready pulses with the accepted transfer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         awready <= 1'b0;
         wready <= 1'b0;
      end else begin
         awready <= take && !awready;
         wready <= take && !awready;
      end
   end
   // response held until bready; always OKAY, unmapped writes dropped
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp <= agr_pkg::RESP_OKAY;
      end else begin
         if (awready) begin
            bvalid <= 1'b1;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
         bresp <= agr_pkg::RESP_OKAY; // R12
      end
   end
   // word select by address bits above bit 1, lsb-justified storage
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         word_a_ff <= agr_pkg::RST_WORD;
         word_b_ff <= agr_pkg::RST_WORD;
      end else if (take && !awready) begin
         if (awaddr[agr_pkg::ADDR_W-1:agr_pkg::WORD_LSB] == agr_pkg::OFS_WORD_A[3:2]) begin // R12
            word_a_ff <= ((word_a_ff & ~strb_mask) | (wdata & strb_mask)) & mask_a; // R09
         end
         if (awaddr[agr_pkg::ADDR_W-1:agr_pkg::WORD_LSB] == agr_pkg::OFS_WORD_B[3:2]) begin // R12
            word_b_ff <= ((word_b_ff & ~strb_mask) | (wdata & strb_mask)) & mask_b; // R09
         end
      end
   end
endmodule // agr_wr_slave
`default_nettype wire

// *** hdl/agr_rd_slave.sv ***
// read channel of one map: returns one of two words by address
// assumes an AXI4-Lite master on core_clk
`timescale 1ns/10ps
`default_nettype none
module agr_rd_slave (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [agr_pkg::ADDR_W-1:0] araddr,
   // read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // words to read
   input wire logic [31:0] word_a,
   input wire logic [31:0] word_b
);
   // -------------------------------------------------------
   // single outstanding read; unmapped words read zero
   // -------------------------------------------------------
   logic take;
   assign take = arvalid && !rvalid && !arready;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= agr_pkg::RST_WORD;
         rresp <= agr_pkg::RESP_OKAY;
      end else begin
         arready <= take;
         rresp <= agr_pkg::RESP_OKAY; // R12
         if (take) begin
            rvalid <= 1'b1;
            if (araddr[agr_pkg::ADDR_W-1:agr_pkg::WORD_LSB] == agr_pkg::OFS_WORD_A[3:2]) begin // R12
               rdata <= word_a; // R09
            end else if (araddr[agr_pkg::ADDR_W-1:agr_pkg::WORD_LSB] == agr_pkg::OFS_WORD_B[3:2]) begin
               rdata <= word_b;
            end else begin
               rdata <= agr_pkg::RST_WORD;
            end
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule // agr_rd_slave
`default_nettype wire

// *** hdl/agr_gateway_regs.sv ***
// top of the gateway register bank: input-port map and output-port map
// assumes two AXI4-Lite masters on core_clk and design ports on core_clk
//
// Notes on behaviour
// [R01] every port register takes its own word-aligned offset, a multiple of four.
// [R02] offsets in each map start at zero.
// [R03] auto-placed registers ascend in the name order of their ports.
// [R04] a port of more than 32 bits is refused at elaboration.
// [R05] a narrow port is driven from the low bits of its register.
// [R06] explicitly placed registers are laid down before auto-placed ones.
// [R07] two equal explicit offsets are an elaboration error.
// [R08] auto-placed registers fill gaps between explicit offsets first.
// [R09] input registers store the low port-width bits of each write and read back, lsb-justified.
// [R10] output registers are read-only; writes do not alter them.
// [R11] all registers act on the rising clock edge.
// [R12] every access answers OKAY and words are chosen by address bits above bit 1.
`timescale 1ns/10ps
`default_nettype none
module agr_gateway_regs #(
   parameter int unsigned IN_W_A = 32,
   parameter int unsigned IN_W_B = 32,
   parameter int unsigned OUT_W_A = 32,
   parameter int unsigned OUT_W_B = 32
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // input map write channels
   input wire logic in_awvalid,
   output logic in_awready,
   input wire logic [agr_pkg::ADDR_W-1:0] in_awaddr,
   input wire logic in_wvalid,
   output logic in_wready,
   input wire logic [31:0] in_wdata,
   input wire logic [3:0] in_wstrb,
   output logic in_bvalid,
   input wire logic in_bready,
   output logic [1:0] in_bresp,
   // input map read channels
   input wire logic in_arvalid,
   output logic in_arready,
   input wire logic [agr_pkg::ADDR_W-1:0] in_araddr,
   output logic in_rvalid,
   input wire logic in_rready,
   output logic [31:0] in_rdata,
   output logic [1:0] in_rresp,
   // output map write channels, accepted and discarded
   input wire logic out_awvalid,
   output logic out_awready,
   input wire logic [agr_pkg::ADDR_W-1:0] out_awaddr,
   input wire logic out_wvalid,
   output logic out_wready,
   input wire logic [31:0] out_wdata,
   input wire logic [3:0] out_wstrb,
   output logic out_bvalid,
   input wire logic out_bready,
   output logic [1:0] out_bresp,
   // output map read channels
   input wire logic out_arvalid,
   output logic out_arready,
   input wire logic [agr_pkg::ADDR_W-1:0] out_araddr,
   output logic out_rvalid,
   input wire logic out_rready,
   output logic [31:0] out_rdata,
   output logic [1:0] out_rresp,
   // design under test ports
   output logic [IN_W_A-1:0] input_port_word_a,
   output logic [IN_W_B-1:0] input_port_word_b,
   input wire logic [OUT_W_A-1:0] output_port_word_a,
   input wire logic [OUT_W_B-1:0] output_port_word_b
);
   // -------------------------------------------------------
   // elaboration checks on the fixed map
   // -------------------------------------------------------
   // map is fixed: a at 0x0, b at 0x4 in each map, in name order
   // both words are placed up front, so no auto-placed word can precede them
   generate // R06
      if (IN_W_A > 32 || IN_W_B > 32 || OUT_W_A > 32 || OUT_W_B > 32) begin : g_too_wide
         $error("port wider than one register word"); // R04
      end
      if (agr_pkg::OFS_WORD_A == agr_pkg::OFS_WORD_B) begin : g_clash
         $error("two register words share one offset"); // R07
      end
      if (agr_pkg::OFS_WORD_A[1:0] != 2'h0 || agr_pkg::OFS_WORD_B[1:0] != 2'h0) begin : g_align
         $error("register offset not word aligned"); // R01
      end
      if (agr_pkg::OFS_WORD_A != 4'h0) begin : g_base
         $error("first register word not at offset zero"); // R02
      end
      if (agr_pkg::OFS_WORD_B <= agr_pkg::OFS_WORD_A) begin : g_order
         $error("register words not ascending in name order"); // R03
      end
      // a hole here would push later words higher than needed
      if (agr_pkg::OFS_WORD_B != agr_pkg::OFS_WORD_A + 4'h4) begin : g_hole
         $error("gap left between register words"); // R08
      end
   endgenerate

   // -------------------------------------------------------
   // input map
   // -------------------------------------------------------
   logic [31:0] word_a;
   logic [31:0] word_b;
   agr_wr_slave #(
      .IN_W_A(IN_W_A),
      .IN_W_B(IN_W_B)
   ) u_in_wr (
      .core_clk(core_clk),
      .rst(rst),
      .awvalid(in_awvalid),
      .awready(in_awready),
      .awaddr(in_awaddr),
      .wvalid(in_wvalid),
      .wready(in_wready),
      .wdata(in_wdata),
      .wstrb(in_wstrb),
      .bvalid(in_bvalid),
      .bready(in_bready),
      .bresp(in_bresp),
      .word_a_ff(word_a),
      .word_b_ff(word_b)
   );
   agr_rd_slave u_in_rd (
      .core_clk(core_clk),
      .rst(rst),
      .arvalid(in_arvalid),
      .arready(in_arready),
      .araddr(in_araddr),
      .rvalid(in_rvalid),
      .rready(in_rready),
      .rdata(in_rdata),
      .rresp(in_rresp),
      .word_a(word_a),
      .word_b(word_b)
   );
   // port drives come from the stored flops' low bits
   assign input_port_word_a = word_a[IN_W_A-1:0]; // R05
   assign input_port_word_b = word_b[IN_W_B-1:0]; // R05

   // -------------------------------------------------------
   // output map: sampled design outputs
   // -------------------------------------------------------
   logic [31:0] out_a_ff;
   logic [31:0] out_b_ff;
   // same clock as the design, so no synchroniser; one cycle of latency
   always_ff @(posedge core_clk or posedge rst) begin // R11
      if (rst) begin
         out_a_ff <= agr_pkg::RST_WORD;
         out_b_ff <= agr_pkg::RST_WORD;
      end else begin
         out_a_ff <= 32'(output_port_word_a);
         out_b_ff <= 32'(output_port_word_b);
      end
   end
   agr_rd_slave u_out_rd (
      .core_clk(core_clk),
      .rst(rst),
      .arvalid(out_arvalid),
      .arready(out_arready),
      .araddr(out_araddr),
      .rvalid(out_rvalid),
      .rready(out_rready),
      .rdata(out_rdata),
      .rresp(out_rresp),
      .word_a(out_a_ff),
      .word_b(out_b_ff)
   );

   // writes to the output map complete OKAY but store nothing
   logic out_take;
   assign out_take = out_awvalid && out_wvalid && !out_bvalid && !out_awready;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_awready <= 1'b0;
         out_wready <= 1'b0;
         out_bvalid <= 1'b0;
         out_bresp <= agr_pkg::RESP_OKAY;
      end else begin
         out_awready <= out_take; // R10
         out_wready <= out_take;
         out_bresp <= agr_pkg::RESP_OKAY; // R12
         if (out_awready) begin
            out_bvalid <= 1'b1;
         end else if (out_bready) begin
            out_bvalid <= 1'b0;
         end
      end
   end
endmodule // agr_gateway_regs
`default_nettype wire

// *** tb/agr_gateway_checker.sv ***
// checker: handshakes, responses and port update of the bank
// assumes a bind into agr_gateway_regs, one clock domain
`timescale 1ns/10ps
`default_nettype none
module agr_gateway_checker #(
   parameter int unsigned IN_W_A = 32
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // input map write
   input wire logic in_awvalid,
   input wire logic in_awready,
   input wire logic [3:0] in_awaddr,
   input wire logic in_wvalid,
   input wire logic in_wready,
   input wire logic [31:0] in_wdata,
   input wire logic [3:0] in_wstrb,
   input wire logic in_bvalid,
   input wire logic in_bready,
   input wire logic [1:0] in_bresp,
   // input map read
   input wire logic in_arvalid,
   input wire logic in_arready,
   input wire logic in_rvalid,
   input wire logic in_rready,
   input wire logic [1:0] in_rresp,
   // design port
   input wire logic [IN_W_A-1:0] input_port_word_a
);
   // ----------
   // properties
   // ----------
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);
   // taken only while nothing is pending
   sequence s_wtake;
      in_awvalid && in_wvalid && !in_awready && !in_bvalid;
   endsequence
   sequence s_wans;
      in_awready && in_wready ##1 in_bvalid;
   endsequence
   property p_wtake;
      s_wtake |=> s_wans;
   endproperty
   a_wtake: assert property (p_wtake)
      else $error("write not answered");
   property p_rtake;
      in_arvalid && !in_arready && !in_rvalid |=> in_arready && in_rvalid;
   endproperty
   a_rtake: assert property (p_rtake)
      else $error("read not answered");
   property p_bokay;
      in_bvalid |-> in_bresp == agr_pkg::RESP_OKAY;
   endproperty
   a_bokay: assert property (p_bokay)
      else $error("write response not okay");
   property p_rokay;
      in_rvalid |-> in_rresp == agr_pkg::RESP_OKAY;
   endproperty
   a_rokay: assert property (p_rokay)
      else $error("read response not okay");
   property p_bhold;
      in_bvalid && !in_bready |=> in_bvalid;
   endproperty
   a_bhold: assert property (p_bhold)
      else $error("write response dropped");
   property p_rdone;
      in_rvalid && in_rready |=> !in_rvalid;
   endproperty
   a_rdone: assert property (p_rdone)
      else $error("read data kept after handshake");
   property p_pulse;
      in_awready |=> !in_awready;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("address ready longer than one cycle");
   // narrow port follows the low bits of a full word write
   property p_port;
      $rose(in_awready) && $past(in_awaddr[3:2]) == 2'h0 && $past(in_wstrb) == 4'hF
         |-> input_port_word_a == $past(in_wdata[IN_W_A-1:0]);
   endproperty
   a_port: assert property (p_port)
      else $error("port a not from low bits");
endmodule // agr_gateway_checker
`default_nettype wire

// *** tb/agr_axil_master.sv ***
// bus master model for one register map, one request at a time
// assumes a slave on core_clk answering with ready and valid levels
`timescale 1ns/10ps
`default_nettype none
module agr_axil_master (
   // clock
   input wire logic core_clk,
   // write channels
   output logic awvalid,
   input wire logic awready,
   output logic [3:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   // read channels
   output logic arvalid,
   input wire logic arready,
   output logic [3:0] araddr,
   input wire logic rvalid,
   output logic rready
);
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wstrb, wdata} = 44'h0;
   end
   // strobes as given; released address and data lines flip so stale values never match
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge core_clk);
      #1 {awaddr, wdata, wstrb, awvalid, wvalid} = {a, v, s, 2'h3};
      do @(posedge core_clk); while (!(awready && wready));
      #1 {awaddr, wdata, awvalid, wvalid, bready} = {~a, ~v, 3'h1};
      do @(posedge core_clk); while (!bvalid);
      #1 bready = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      #1 {araddr, arvalid} = {a, 1'b1};
      do @(posedge core_clk); while (!arready);
      #1 {araddr, arvalid, rready} = {~a, 2'h1};
      do @(posedge core_clk); while (!rvalid);
      #1 rready = 1'b0;
   endtask
endmodule // agr_axil_master
`default_nettype wire

// *** tb/tb_top.sv ***
// bench: bank, two bus masters, port stimulus and read scoreboard
// assumes agr_pkg, the master model and the checker compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic in_awvalid, in_awready, in_wvalid, in_wready, in_bvalid, in_bready;
   logic in_arvalid, in_arready, in_rvalid, in_rready, out_awvalid, out_awready;
   logic out_wvalid, out_wready, out_bvalid, out_bready;
   logic out_arvalid, out_arready, out_rvalid, out_rready;
   logic [3:0] in_awaddr, in_wstrb, in_araddr, out_awaddr, out_wstrb, out_araddr;
   logic [31:0] in_wdata, in_rdata, out_wdata, out_rdata, d, wa, wb;
   logic [1:0] in_bresp, in_rresp, out_bresp, out_rresp;
   logic [15:0] input_port_word_a, output_port_word_a = 16'h0000, output_port_word_b = 16'h0000;
   logic [23:0] input_port_word_b;
   logic [33:0] q[$];
   logic [15:0] lf = 16'hF8C5;
   int n_mismatch = 0;
   int compares = 0;
   always #2.5 core_clk = ~core_clk;
   agr_gateway_regs #(.IN_W_A(16), .IN_W_B(24), .OUT_W_A(16), .OUT_W_B(16)) i_agr_gateway_regs (.*);
   agr_axil_master m_in (.core_clk(core_clk), .awvalid(in_awvalid), .awready(in_awready),
      .awaddr(in_awaddr), .wvalid(in_wvalid), .wready(in_wready), .wdata(in_wdata), .wstrb(in_wstrb),
      .bvalid(in_bvalid), .bready(in_bready), .arvalid(in_arvalid), .arready(in_arready),
      .araddr(in_araddr), .rvalid(in_rvalid), .rready(in_rready));
   agr_axil_master m_out (.core_clk(core_clk), .awvalid(out_awvalid), .awready(out_awready),
      .awaddr(out_awaddr), .wvalid(out_wvalid), .wready(out_wready), .wdata(out_wdata), .wstrb(out_wstrb),
      .bvalid(out_bvalid), .bready(out_bready), .arvalid(out_arvalid), .arready(out_arready),
      .araddr(out_araddr), .rvalid(out_rvalid), .rready(out_rready));
   function automatic logic [31:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return {lf, ~lf};
   endfunction
   task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // note the expected word, then read it through one map
   task automatic rdx(input int sel, input logic [3:0] a, input logic [31:0] v);
      q.push_back({agr_pkg::RESP_OKAY, v});
      if (sel != 0) m_out.rd(a);
      else m_in.rd(a);
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // scoreboard: oldest note against every finished read
   always @(posedge core_clk) begin
      if ((in_rvalid && in_rready) || (out_rvalid && out_rready)) begin
         chk("read word", in_rvalid ? {in_rresp, in_rdata} : {out_rresp, out_rdata}, q.pop_front());
      end
      if ((in_bvalid && in_bready) || (out_bvalid && out_bready)) begin
         chk("write response", {32'h0, in_bvalid ? in_bresp : out_bresp}, {32'h0, agr_pkg::RESP_OKAY});
      end
   end
   initial begin
      #10000 n_mismatch++;
      summarize();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      #1 rst = 1'b0;
      rdx(0, agr_pkg::OFS_WORD_A, agr_pkg::RST_WORD);
      rdx(0, agr_pkg::OFS_WORD_B, agr_pkg::RST_WORD);
      // back-to-back writes; narrow ports keep the low bits only
      for (int i = 0; i < 6; i++) begin
         wa = rnd();
         wb = rnd();
         m_in.wr(4'h0, wa, 4'hF);
         m_in.wr(4'h4, wb, 4'hF);
         wa = wa & 32'h0000FFFF;
         wb = wb & 32'h00FFFFFF;
         chk("port a", {18'h0, input_port_word_a}, {2'h0, wa});
         chk("port b", {10'h0, input_port_word_b}, {2'h0, wb});
         rdx(0, 4'h0, wa);
         rdx(0, 4'h6, wb);
      end
      d = rnd();
      m_in.wr(4'h0, d, 4'h1);
      rdx(0, 4'h0, {wa[31:8], d[7:0]});
      m_in.wr(4'h8, rnd(), 4'hF);
      rdx(0, 4'h8, 32'h0);
      rdx(0, 4'h4, wb);
      // output words follow the ports and ignore writes
      for (int i = 0; i < 3; i++) begin
         d = rnd();
         {output_port_word_b, output_port_word_a} = d;
         m_out.wr(4'h0, ~d, 4'hF);
         m_out.wr(4'h4, ~d, 4'hF);
         rdx(1, 4'h0, {16'h0, d[15:0]});
         rdx(1, 4'h4, {16'h0, d[31:16]});
      end
      summarize();
   end
endmodule // tb_top
bind agr_gateway_regs agr_gateway_checker #(.IN_W_A(IN_W_A)) i_agr_gateway_checker (.*);
`default_nettype wire
